/* src/prg_defines.svh */
`ifndef PRG_DEFINES_SVH
`define PRG_DEFINES_SVH

// Program counter value taken after every reset.
`define PRG_RESET_VECTOR 16'h0000
// Word address pointer width, before trimming to the memory depth.
`define PRG_PTR_W 16
// Documented program memory word width.
`define PRG_WORD_W 16
// Default address width: 13 bits give the largest variant, 8K words.
`define PRG_ADDR_W_DEF 13
// Byte fields of a program word.
`define PRG_LO_LSB 0
`define PRG_HI_LSB 8
// System clocks per instruction cycle (T1 to T4).
`define PRG_CLK_PER_ICYC 4
// Instruction cycles taken by any table instruction.
`define PRG_TBL_ICYC 2
// Serial programming frame: 16 address bits then 16 data bits, MSB first.
`define PRG_ICP_FRAME_BITS 32
`define PRG_ICP_ADDR_LSB 16

`endif

/* src/prg_flash_array.sv */
`timescale 1ns/10ps
module prg_flash_array
   import prg_pkg::*;
#(
   parameter int ADDR_W = 13
) (
   // Clock.
   input wire logic clock,
   // Access ports.
   prg_mem_if.mem port
);
   // One 16-bit word per address, depth set by the variant.
   prg_word_t words [2**ADDR_W];
   prg_word_t rd_data_r;

   always_ff @(posedge clock) begin
      if (port.wr_en) begin
         words[port.wr_addr] <= port.wr_data;
      end
      rd_data_r <= words[port.rd_addr];
   end

   assign port.rd_data = rd_data_r;
endmodule : prg_flash_array

/* src/prg_icp_link.sv */
`timescale 1ns/10ps
`include "prg_defines.svh"
module prg_icp_link
   import prg_pkg::*;
#(
   parameter int ADDR_W = 13
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Link enable and pins.
   input wire logic enable,
   input wire logic sclk_in,
   input wire logic sdata_in,
   output logic sdata_out,
   output logic sdata_oe,
   // Memory write port.
   prg_mem_if.writer wr
);
   typedef struct packed {
      logic sclk_q;
      logic [5:0] cnt;
      logic [31:0] shift;
      logic ack;
      logic wr_en;
      logic [ADDR_W-1:0] wr_addr;
      prg_word_t wr_data;
   } prg_icp_s;

   prg_icp_s s_r, s_nxt;
   logic rise;

   assign rise = sclk_in && !s_r.sclk_q;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sclk_q = sclk_in;
      s_nxt.wr_en = 1'b0;
      if (!enable) begin
         s_nxt.cnt = 6'h00;
         s_nxt.ack = 1'b0;
      end else if (rise) begin
         if (s_r.ack) begin
            // The acknowledge low is released on the next serial clock.
            s_nxt.ack = 1'b0;
         end else begin
            s_nxt.shift = {s_r.shift[30:0], sdata_in};
            if (s_r.cnt == 6'(`PRG_ICP_FRAME_BITS - 1)) begin
               s_nxt.cnt = 6'h00;
               s_nxt.ack = 1'b1;
               s_nxt.wr_en = 1'b1;
               s_nxt.wr_addr = s_r.shift[`PRG_ICP_ADDR_LSB - 1 +: ADDR_W];
               s_nxt.wr_data = {s_r.shift[14:0], sdata_in};
            end else begin
               s_nxt.cnt = s_r.cnt + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sdata_out = 1'b0;
   assign sdata_oe = s_r.ack;
   assign wr.wr_en = s_r.wr_en;
   assign wr.wr_addr = s_r.wr_addr;
   assign wr.wr_data = s_r.wr_data;

   frame_ack_a: assert property (@(posedge clock) disable iff (!resetn)
      s_r.wr_en |-> sdata_oe ##1 enable && rise |=> !sdata_oe)
      else $error("Write frame not followed by acknowledge on the data line.");

   ack_release_a: assert property (@(posedge clock) disable iff (!resetn)
      s_r.ack && enable && rise |=> !sdata_oe && s_r.cnt == 6'h00)
      else $error("Acknowledge not released by the next serial clock.");
endmodule : prg_icp_link

/* src/prg_mem_if.sv */
`timescale 1ns/10ps
interface prg_mem_if #(
   parameter int ADDR_W = 13
);
   logic [ADDR_W-1:0] rd_addr;
   logic [15:0] rd_data;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [15:0] wr_data;

   modport reader (output rd_addr, input rd_data);
   modport writer (output wr_en, output wr_addr, output wr_data);
   modport mem (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : prg_mem_if

/* src/prg_pkg.sv */
package prg_pkg;

   typedef enum logic [0:0] {
      PRG_TBL_IDLE,
      PRG_TBL_READ
   } prg_tbl_e;

   typedef logic [15:0] prg_word_t;

endpackage : prg_pkg

/* src/prg_table_read.sv */
`timescale 1ns/10ps
`include "prg_defines.svh"
module prg_table_read
   import prg_pkg::*;
#(
   parameter int ADDR_W = `PRG_ADDR_W_DEF,
   parameter int STORED_W = `PRG_WORD_W,
   parameter bit EMULATION = 1'b0
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Fetch side of the core.
   input wire logic pc_load,
   input wire logic [15:0] pc_target,
   output logic fetch_valid_r,
   output logic [15:0] fetch_addr_r,
   output logic [15:0] fetch_word_r,
   // Table pointer writes from the core.
   input wire logic tblp_wr,
   input wire logic tbhp_wr,
   input wire logic [7:0] ptr_wdata,
   // Table read instruction.
   input wire logic table_read_op,
   input wire logic table_read_last_page_op,
   input wire logic [7:0] table_dest,
   output logic table_busy_r,
   output logic icyc_tick_r,
   // Data memory write and holding latch.
   output logic dm_wr_r,
   output logic [7:0] dm_addr_r,
   output logic [7:0] dm_data_r,
   output logic [7:0] table_high_latch_r,
   // Shared pins.
   input wire logic prog_mode,
   input wire logic port_a_bit0_pin_in,
   output logic port_a_bit0_pin_out_r,
   output logic port_a_bit0_pin_oe_r,
   input wire logic port_a_bit2_pin_in,
   // General purpose port side of the shared pins.
   input wire logic gpio_a0_out,
   input wire logic gpio_a0_oe,
   output logic gpio_a0_in_r,
   output logic gpio_a2_in_r,
   // Debugger view of the pins on the emulation variant.
   output logic debug_serial_data_r,
   output logic debug_serial_clock_r
);
   localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_W) - 1);
   localparam logic [7:0] HI_MASK = 8'((32'h1 << (STORED_W - 8)) - 1);
   localparam logic [1:0] PHASE_LAST = 2'(`PRG_CLK_PER_ICYC - 1);
   localparam logic [1:0] TBL_LAST = 2'(`PRG_TBL_ICYC - 1);

   if (ADDR_W < 11 || ADDR_W > 13) begin : g_addr_chk
      $error("ADDR_W must be 11, 12 or 13.");
   end
   if (STORED_W < 9 || STORED_W > 16) begin : g_width_chk
      $error("STORED_W must lie between 9 and 16.");
   end

   typedef struct packed {
      logic [1:0] phase;
      logic tick;
      logic [15:0] pc;
      logic [7:0] tblp;
      logic [7:0] tbhp;
      prg_tbl_e tst;
      logic [1:0] icnt;
      logic [15:0] taddr;
      logic [7:0] dest;
      prg_word_t tword;
      logic busy;
      logic fvalid;
      logic [15:0] faddr;
      prg_word_t fword;
      logic dm_wr;
      logic [7:0] dm_addr;
      logic [7:0] dm_data;
      logic [7:0] thl;
      logic pin_out;
      logic pin_oe;
      logic a0_in;
      logic a2_in;
      logic dbg_data;
      logic dbg_clk;
   } prg_top_s;

   prg_top_s s_r, s_nxt;
   logic accept;
   logic complete;
   logic icp_en;
   logic icp_out;
   logic icp_oe;

   prg_mem_if #(.ADDR_W(ADDR_W)) mem_port ();

   prg_flash_array #(.ADDR_W(ADDR_W)) u_array (
      .clock (clock),
      .port (mem_port)
   );

   // The programming link owns the pins whenever programming is entered.
   assign icp_en = prog_mode;

   prg_icp_link #(.ADDR_W(ADDR_W)) u_icp (
      .clock (clock),
      .resetn (resetn),
      .enable (icp_en),
      .sclk_in (port_a_bit2_pin_in),
      .sdata_in (port_a_bit0_pin_in),
      .sdata_out (icp_out),
      .sdata_oe (icp_oe),
      .wr (mem_port)
   );

   // While a table read runs the array serves the table pointer, not the fetch.
   assign mem_port.rd_addr = (s_r.tst == PRG_TBL_READ) ? s_r.taddr[ADDR_W-1:0] :
      s_r.pc[ADDR_W-1:0];

   assign accept = s_r.tick && table_read_op && !s_r.busy;
   assign complete = s_r.tick && (s_r.tst == PRG_TBL_READ) && (s_r.icnt == TBL_LAST);

   always_comb begin
      s_nxt = s_r;
      s_nxt.phase = s_r.phase + 2'h1;
      s_nxt.tick = (s_r.phase == PHASE_LAST);
      s_nxt.fvalid = 1'b0;
      s_nxt.dm_wr = 1'b0;

      if (tblp_wr) begin
         s_nxt.tblp = ptr_wdata;
      end
      if (tbhp_wr) begin
         s_nxt.tbhp = ptr_wdata;
      end

      // Normal fetch advances once per instruction cycle.
      if (s_r.tick && !s_r.busy) begin
         s_nxt.fvalid = 1'b1;
         s_nxt.faddr = s_r.pc;
         s_nxt.fword = mem_port.rd_data;
         s_nxt.pc = pc_load ? (pc_target & ADDR_MASK) : ((s_r.pc + 16'h0001) & ADDR_MASK);
      end

      if (accept) begin
         s_nxt.tst = PRG_TBL_READ;
         s_nxt.busy = 1'b1;
         s_nxt.icnt = 2'h0;
         s_nxt.dest = table_dest;
         if (table_read_last_page_op) begin
            s_nxt.taddr = ADDR_MASK & {8'hff, s_r.tblp};
         end else begin
            s_nxt.taddr = ADDR_MASK & {s_r.tbhp, s_r.tblp};
         end
      end else if (s_r.tst == PRG_TBL_READ) begin
         s_nxt.tword = mem_port.rd_data;
         if (s_r.tick) begin
            s_nxt.icnt = s_r.icnt + 2'h1;
         end
         if (complete) begin
            s_nxt.tst = PRG_TBL_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.dm_wr = 1'b1;
            s_nxt.dm_addr = s_r.dest;
            s_nxt.dm_data = s_r.tword[`PRG_LO_LSB +: 8];
            // Only the table read itself loads the latch; there is no write path.
            s_nxt.thl = s_r.tword[`PRG_HI_LSB +: 8] & HI_MASK;
         end
      end

      // Pin ownership: programming first, then debugger or general purpose use.
      s_nxt.a2_in = 1'b0;
      s_nxt.a0_in = 1'b0;
      s_nxt.dbg_data = 1'b0;
      s_nxt.dbg_clk = 1'b0;
      if (prog_mode) begin
         s_nxt.pin_out = icp_out;
         s_nxt.pin_oe = icp_oe;
      end else if (EMULATION) begin
         s_nxt.pin_out = 1'b0;
         s_nxt.pin_oe = 1'b0;
         s_nxt.dbg_data = port_a_bit0_pin_in;
         s_nxt.dbg_clk = port_a_bit2_pin_in;
      end else begin
         s_nxt.pin_out = gpio_a0_out;
         s_nxt.pin_oe = gpio_a0_oe;
         s_nxt.a0_in = port_a_bit0_pin_in;
         s_nxt.a2_in = port_a_bit2_pin_in;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.pc <= `PRG_RESET_VECTOR;
         s_r.tst <= PRG_TBL_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign fetch_valid_r = s_r.fvalid;
   assign fetch_addr_r = s_r.faddr;
   assign fetch_word_r = s_r.fword;
   assign table_busy_r = s_r.busy;
   assign icyc_tick_r = s_r.tick;
   assign dm_wr_r = s_r.dm_wr;
   assign dm_addr_r = s_r.dm_addr;
   assign dm_data_r = s_r.dm_data;
   assign table_high_latch_r = s_r.thl;
   assign port_a_bit0_pin_out_r = s_r.pin_out;
   assign port_a_bit0_pin_oe_r = s_r.pin_oe;
   assign gpio_a0_in_r = s_r.a0_in;
   assign gpio_a2_in_r = s_r.a2_in;
   assign debug_serial_data_r = s_r.dbg_data;
   assign debug_serial_clock_r = s_r.dbg_clk;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   reset_vector_a: assert property (
      $rose(resetn) |-> s_r.pc == `PRG_RESET_VECTOR ##[1:5] fetch_valid_r && fetch_addr_r == 16'h0000)
      else $error("First fetch after reset is not at word zero.");

   table_two_cycles_a: assert property (
      accept |=> table_busy_r [*8] ##1 dm_wr_r && !table_busy_r)
      else $error("Table read did not take exactly two instruction cycles.");

   table_address_a: assert property (
      accept && !table_read_last_page_op |=>
      s_r.taddr == (ADDR_MASK & {$past(s_r.tbhp), $past(s_r.tblp)}))
      else $error("Table address not formed from both pointer registers.");

   last_page_a: assert property (
      accept && table_read_last_page_op |=> s_r.taddr == (ADDR_MASK & {8'hff, $past(s_r.tblp)}))
      else $error("Last page table read used the wrong page.");

   pc_held_a: assert property (
      table_busy_r && $past(table_busy_r) |-> $stable(s_r.pc) && !fetch_valid_r)
      else $error("Program counter moved during a table read.");

   low_byte_a: assert property (
      complete |=> dm_wr_r && dm_data_r == $past(s_r.tword[7:0]) && dm_addr_r == $past(s_r.dest))
      else $error("Low table byte not written to the operand location.");

   high_latch_a: assert property (
      complete |=> table_high_latch_r == ($past(s_r.tword[15:8]) & HI_MASK))
      else $error("Holding latch did not take the masked high byte.");

   latch_only_read_a: assert property (
      !$stable(table_high_latch_r) |-> dm_wr_r)
      else $error("Holding latch changed outside a table read.");

   emu_pins_a: assert property (
      EMULATION && !prog_mode |=> !port_a_bit0_pin_oe_r && !gpio_a0_in_r && !gpio_a2_in_r)
      else $error("Shared pin function active on the emulation variant.");

   prog_pins_a: assert property (
      prog_mode |=> port_a_bit0_pin_oe_r == $past(icp_oe) && !gpio_a0_in_r)
      else $error("Programming link does not own the shared pins.");
endmodule : prg_table_read

/* testbench/prg_prog_model.sv */
`timescale 1ns/10ps
module prg_prog_model (
   // System clock and device side of the data pin.
   input wire logic clock,
   input wire logic dev_oe,
   input wire logic dev_out,
   // Programmer drive of the two pins.
   output logic sclk,
   output logic sdata,
   output logic sdata_en
);
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      sdata_en = 1'b0;
   end

   // Shifts one frame, address then data, MSB first, and waits a bounded time for the
   // acknowledge. The serial clock stands low outside frames.
   task automatic send_frame(input logic [15:0] addr, input logic [15:0] data,
                             input int half, output logic ack);
      logic [31:0] frame;
      frame = {addr, data};
      ack = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         @(posedge clock);
         #1;
         sdata_en = 1'b1;
         sdata = frame[i];
         repeat (half) @(posedge clock);
         #1;
         sclk = 1'b1;
         repeat (half) @(posedge clock);
         #1;
         sclk = 1'b0;
      end
      sdata_en = 1'b0;
      for (int n = 0; n < 12 && !ack; n++) begin
         @(posedge clock);
         #1;
         ack = dev_oe && !dev_out;
      end
      // One extra serial clock hands the data line back after the acknowledge.
      if (ack) begin
         repeat (half) @(posedge clock);
         #1;
         sclk = 1'b1;
         repeat (half) @(posedge clock);
         #1;
         sclk = 1'b0;
      end
   endtask : send_frame
endmodule : prg_prog_model

/* testbench/test_prg_table_read.sv */
`timescale 1ns/10ps
module test_prg_table_read;
   import prg_pkg::*;

   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic tblp_wr = 1'b0;
   logic tbhp_wr = 1'b0;
   logic [7:0] ptr_wdata = 8'h00;
   logic table_read_op = 1'b0;
   logic table_read_last_page_op = 1'b0;
   logic [7:0] table_dest = 8'h00;
   logic prog_mode = 1'b0;
   logic gpio_a0_out = 1'b0;
   logic gpio_a0_oe = 1'b0;
   logic fetch_valid_r, table_busy_r, icyc_tick_r, dm_wr_r;
   logic [15:0] fetch_addr_r;
   logic [7:0] dm_addr_r, dm_data_r, table_high_latch_r;
   logic pin0_out, pin0_oe, pin0, sclk, sdata, sdata_en, gpio_a0_in_r, gpio_a2_in_r;
   int n_mismatch = 0;
   int comparisons = 0;

   always #5 clock = ~clock;

   // A released data line shows the inverse of the last bit the programmer drove.
   assign pin0 = pin0_oe ? pin0_out : (sdata_en ? sdata : ~sdata);

   prg_table_read #(.ADDR_W(13), .STORED_W(14), .EMULATION(1'b0)) prg_table_read_i (
      .clock(clock), .resetn(resetn), .pc_load(1'b0), .pc_target(16'h0000),
      .fetch_valid_r(fetch_valid_r), .fetch_addr_r(fetch_addr_r), .fetch_word_r(),
      .tblp_wr(tblp_wr), .tbhp_wr(tbhp_wr), .ptr_wdata(ptr_wdata),
      .table_read_op(table_read_op), .table_read_last_page_op(table_read_last_page_op),
      .table_dest(table_dest), .table_busy_r(table_busy_r), .icyc_tick_r(icyc_tick_r),
      .dm_wr_r(dm_wr_r), .dm_addr_r(dm_addr_r), .dm_data_r(dm_data_r),
      .table_high_latch_r(table_high_latch_r), .prog_mode(prog_mode),
      .port_a_bit0_pin_in(pin0), .port_a_bit0_pin_out_r(pin0_out),
      .port_a_bit0_pin_oe_r(pin0_oe), .port_a_bit2_pin_in(sclk),
      .gpio_a0_out(gpio_a0_out), .gpio_a0_oe(gpio_a0_oe), .gpio_a0_in_r(gpio_a0_in_r),
      .gpio_a2_in_r(gpio_a2_in_r), .debug_serial_data_r(), .debug_serial_clock_r()
   );

   prg_prog_model prg_prog_model_i (
      .clock(clock), .dev_oe(pin0_oe), .dev_out(pin0_out),
      .sclk(sclk), .sdata(sdata), .sdata_en(sdata_en)
   );

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // Holds reset, releases it and expects the first fetch at word zero.
   task automatic do_reset(input int cycles);
      int n;
      @(posedge clock);
      #1;
      resetn = 1'b0;
      repeat (cycles) @(posedge clock);
      #1;
      resetn = 1'b1;
      n = 0;
      while (fetch_valid_r !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      check("first fetch", {15'h0, fetch_valid_r}, 16'h0001);
      check("fetch address", fetch_addr_r, 16'h0000);
      $display("test reset %0d done", cycles);
   endtask : do_reset

   // Writes one word through the serial link and expects the acknowledge.
   task automatic program_word(input logic [15:0] addr, input logic [15:0] data, input int half);
      logic ack;
      prog_mode = 1'b1;
      prg_prog_model_i.send_frame(addr, data, half, ack);
      check("acknowledge", {15'h0, ack}, 16'h0001);
      check("port pin levels", {14'h0, gpio_a0_in_r, gpio_a2_in_r}, 16'h0000);
      check("acknowledge released", {15'h0, pin0_oe}, 16'h0000);
      $display("test program %h done", addr);
   endtask : program_word

   // Sets the pointer, issues one read held high into the busy span, and checks the timing.
   task automatic table_read(input logic [7:0] hi, input logic [7:0] lo, input logic last,
                             input logic [7:0] dest, input logic [15:0] word);
      int n;
      @(posedge clock);
      #1;
      tblp_wr = 1'b1;
      ptr_wdata = lo;
      @(posedge clock);
      #1;
      tblp_wr = 1'b0;
      tbhp_wr = 1'b1;
      ptr_wdata = hi;
      @(posedge clock);
      #1;
      tbhp_wr = 1'b0;
      n = 0;
      while (icyc_tick_r !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1;
         n++;
      end
      table_read_op = 1'b1;
      table_read_last_page_op = last;
      table_dest = dest;
      for (int k = 1; k <= 14; k++) begin
         @(posedge clock);
         #1;
         check("busy", {15'h0, table_busy_r}, {15'h0, k <= 8});
         check("data write", {15'h0, dm_wr_r}, {15'h0, k == 9});
         if (k == 5 || k == 9) begin
            check("fetch stalled", {15'h0, fetch_valid_r}, 16'h0000);
         end
         if (k == 9) begin
            table_read_op = 1'b0;
            check("data address", {8'h0, dm_addr_r}, {8'h0, dest});
            check("low byte", {8'h0, dm_data_r}, {8'h0, word[7:0]});
            check("high latch", {8'h0, table_high_latch_r}, {8'h0, word[15:8] & 8'h3f});
         end
      end
      $display("test table read %h%h done", hi, lo);
   endtask : table_read

   // Outside programming the port logic drives pin 0 and sees both pin levels.
   task automatic port_pins;
      @(posedge clock);
      #1;
      gpio_a0_out = 1'b1;
      gpio_a0_oe = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check("port drive", {14'h0, pin0_oe, pin0_out}, 16'h0003);
      check("port levels", {14'h0, gpio_a0_in_r, gpio_a2_in_r}, 16'h0002);
      gpio_a0_out = 1'b0;
      gpio_a0_oe = 1'b0;
      $display("test port pins done");
   endtask : port_pins

   initial begin
      do_reset(20);
      program_word(16'h0706, 16'hfc1a, 2);
      program_word(16'h1f05, 16'h7e0f, 5);
      prog_mode = 1'b0;
      port_pins();
      table_read(8'h07, 8'h06, 1'b0, 8'h80, 16'hfc1a);
      table_read(8'h00, 8'h05, 1'b1, 8'h81, 16'h7e0f);
      table_read(8'he7, 8'h06, 1'b0, 8'h82, 16'hfc1a);
      do_reset(3);
      table_read(8'hff, 8'h05, 1'b0, 8'h83, 16'h7e0f);
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule : test_prg_table_read
